// ### verilog/clk_ratio_pkg.sv
`default_nettype none
package clk_ratio_pkg;

  // ****************************************
  // Strap field and ratio encoding
  // ****************************************
  localparam int STRAP_W = 4;
  localparam int RATIO_W = 5;
  localparam logic [3:0] CODE_R16 = 4'h0;
  localparam logic [3:0] CODE_R2 = 4'h2;
  localparam logic [3:0] CODE_R3 = 4'h3;
  localparam logic [3:0] CODE_R4 = 4'h4;
  localparam logic [3:0] CODE_R5 = 4'h5;
  localparam logic [3:0] CODE_R6 = 4'h6;
  localparam logic [3:0] CODE_R8 = 4'h8;
  localparam logic [3:0] CODE_R9 = 4'h9;
  localparam logic [3:0] CODE_R10 = 4'hA;
  localparam logic [3:0] CODE_R12 = 4'hC;

  // ****************************************
  // Values after reset and fixed ratios
  // ****************************************
  localparam logic [4:0] RATIO_RST = 5'h00;
  localparam logic [3:0] STRAP_RST = 4'h0;
  localparam logic [3:0] CORE_RATIO_RST = 4'h0;
  localparam logic [4:0] COMMS_RATIO = 5'h02;
  localparam logic [4:0] PCI_PLL_RATIO = 5'h01;

  // ****************************************
  // Timing: strap sampled after settling cycles counted from reset release
  // ****************************************
  localparam int SETTLE_CYC = 4;
  localparam logic [2:0] SETTLE_RST = 3'h0;

  // Decode a strap code to its multiplier; zero marks a reserved code.
  function automatic logic [4:0] ratio_of(input logic [3:0] code);
    logic [4:0] r;
    r = 5'h00;
    unique case (code)
      CODE_R16: r = 5'h10;
      CODE_R2: r = 5'h02;
      CODE_R3: r = 5'h03;
      CODE_R4: r = 5'h04;
      CODE_R5: r = 5'h05;
      CODE_R6: r = 5'h06;
      CODE_R8: r = 5'h08;
      CODE_R9: r = 5'h09;
      CODE_R10: r = 5'h0A;
      CODE_R12: r = 5'h0C;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

endpackage
`default_nettype wire

// ### verilog/sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second, keeping metastability contained.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### verilog/platform_clock_ratio_strap.sv
// Functional notes
// - Power-up samples the four ratio strap pins to select platform multiplier.
// - Codes 0000=16, 0010-0110=2-6, 1000-1010=8-10, 1100=12; others reserved.
// - Platform ratio drives L2 cache, DDR data rate and coherency bus.
// - Core clock ratio follows platform clock via separate core ratio bits.
// - Comms module PLL follows platform clock at a fixed ratio.
// - Each of two PCI buses has its own PLL enable; both are set together at capture.
// - Soft reset input assertion raises a machine check to the core.
`timescale 1ns/1ps
`default_nettype none
module platform_clock_ratio_strap
  import clk_ratio_pkg::*;
#(
  parameter int SETTLE = clk_ratio_pkg::SETTLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [clk_ratio_pkg::STRAP_W-1:0] ratio_strap_pins_i,
  input wire logic [3:0] core_ratio_cfg_i,
  input wire logic soft_reset_input_n_i,
  input wire logic hard_reset_input_n_i,
  input wire logic debug_hard_reset_input_n_i,
  input wire logic debug_trst_n_i,
  input wire logic board_trst_n_i,
  output logic [clk_ratio_pkg::RATIO_W-1:0] platform_ratio_o,
  output logic ratio_valid_o,
  output logic ratio_reserved_o,
  output logic [clk_ratio_pkg::RATIO_W-1:0] l2_ratio_o,
  output logic [clk_ratio_pkg::RATIO_W-1:0] ddr_ratio_o,
  output logic [clk_ratio_pkg::RATIO_W-1:0] coherency_bus_ratio_o,
  output logic [3:0] core_ratio_o,
  output logic [clk_ratio_pkg::RATIO_W-1:0] comms_module_ratio_o,
  output logic pci1_pll_en_o,
  output logic pci2_pll_en_o,
  output logic machine_check_o,
  output logic core_hard_reset_input_n_o,
  output logic core_trst_n_o
);
  import clk_ratio_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [STRAP_W-1:0] strap_s;
  logic [3:0] core_cfg_s;
  logic [4:0] ctl_s;

  // All board-side levels cross two flops before any logic reads them.
  // Strap stages are not reset, so real pin levels reach the capture even with a short settle.
  sync_2ff #(.W(STRAP_W)) u_strap_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(1'b1),
    .ce_i(ce_i),
    .d_i(ratio_strap_pins_i),
    .q_o(strap_s)
  );

  sync_2ff #(.W(4)) u_core_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(1'b1),
    .ce_i(ce_i),
    .d_i(core_ratio_cfg_i),
    .q_o(core_cfg_s)
  );

  sync_2ff #(.W(5)) u_ctl_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(1'b1),
    .ce_i(ce_i),
    .d_i({soft_reset_input_n_i, hard_reset_input_n_i, debug_hard_reset_input_n_i,
          debug_trst_n_i, board_trst_n_i}),
    .q_o(ctl_s)
  );

  // ****************************************
  // Power-up strap capture
  // ****************************************
  logic [2:0] settle_r;
  logic [STRAP_W-1:0] strap_r;
  logic [3:0] core_r;
  logic latched_r;

  // Count cycles after reset release so the synchroniser holds real pin values.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      settle_r <= SETTLE_RST;
    end else if (ce_i && !latched_r && settle_r != 3'(SETTLE)) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // Capture once; later pin moves are ignored until rst_n_i is asserted again.
  // Functional reset on rst_n_i clears latched_r, so every reset recaptures the straps.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      latched_r <= 1'b0;
      strap_r <= STRAP_RST;
      core_r <= CORE_RATIO_RST;
    end else if (ce_i && !latched_r && settle_r == 3'(SETTLE)) begin
      latched_r <= 1'b1;
      strap_r <= strap_s;
      core_r <= core_cfg_s;
    end
  end

  // ****************************************
  // Ratio distribution
  // ****************************************
  // Reserved codes give a zero multiplier and a flag rather than a guess.
  // Before the capture every ratio reads zero, so nothing starts on the reset strap value.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      platform_ratio_o <= RATIO_RST;
      l2_ratio_o <= RATIO_RST;
      ddr_ratio_o <= RATIO_RST;
      coherency_bus_ratio_o <= RATIO_RST;
      core_ratio_o <= CORE_RATIO_RST;
      comms_module_ratio_o <= RATIO_RST;
      ratio_valid_o <= 1'b0;
      ratio_reserved_o <= 1'b0;
      pci1_pll_en_o <= 1'b0;
      pci2_pll_en_o <= 1'b0;
    end else if (ce_i) begin
      platform_ratio_o <= latched_r ? ratio_of(strap_r) : RATIO_RST;
      l2_ratio_o <= latched_r ? ratio_of(strap_r) : RATIO_RST;
      ddr_ratio_o <= latched_r ? ratio_of(strap_r) : RATIO_RST;
      coherency_bus_ratio_o <= latched_r ? ratio_of(strap_r) : RATIO_RST;
      core_ratio_o <= core_r;
      comms_module_ratio_o <= latched_r ? COMMS_RATIO : RATIO_RST;
      ratio_valid_o <= latched_r && ratio_of(strap_r) != 5'h00;
      ratio_reserved_o <= latched_r && ratio_of(strap_r) == 5'h00;
      pci1_pll_en_o <= latched_r;
      pci2_pll_en_o <= latched_r;
    end
  end

  // ****************************************
  // Reset and debug paths
  // ****************************************
  logic soft_reset_input_d_r;

  // Falling edge of the synchronised soft reset gives a one-cycle machine check.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_reset_input_d_r <= 1'b1;
      machine_check_o <= 1'b0;
    end else if (ce_i) begin
      soft_reset_input_d_r <= ctl_s[4];
      machine_check_o <= soft_reset_input_d_r && !ctl_s[4];
    end
  end

  // Either source alone can hold the core in reset or reset its test logic.
  // These flops skip the clock enable, but u_ctl_sync is gated by ce_i, so a frozen block holds its reset outputs.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_hard_reset_input_n_o <= 1'b0;
      core_trst_n_o <= 1'b0;
    end else begin
      core_hard_reset_input_n_o <= ctl_s[3] & ctl_s[2];
      core_trst_n_o <= ctl_s[1] & ctl_s[0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_strap_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    latched_r |=> $stable(strap_r))
    else $error("Latched strap changed.");

  // Before the capture the ratio must read zero, never a decode of the reset strap.
  a_ratio_decode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i |=> platform_ratio_o == ($past(latched_r) ? ratio_of($past(strap_r)) : RATIO_RST))
    else $error("Platform ratio does not match strap.");

  a_capture_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && !latched_r && settle_r == 3'(SETTLE)) |=> latched_r && strap_r == $past(strap_s))
    else $error("Strap not captured.");

  a_flag_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(ratio_valid_o && ratio_reserved_o))
    else $error("Valid and reserved flags both set.");

  // A reserved code must never reach the clock tree as a nonzero multiplier.
  a_resv_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ratio_reserved_o |-> platform_ratio_o == RATIO_RST)
    else $error("Reserved code gave a multiplier.");

  a_bus_fanout: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    l2_ratio_o == platform_ratio_o && ddr_ratio_o == platform_ratio_o
    && coherency_bus_ratio_o == platform_ratio_o)
    else $error("Platform ratio fan-out differs.");

  a_core_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && latched_r) |=> core_ratio_o == $past(core_r))
    else $error("Core ratio not from latched bits.");

  a_comms_fixed: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && latched_r) |=> comms_module_ratio_o == COMMS_RATIO)
    else $error("Comms module ratio not fixed.");

  a_comms_before: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && !latched_r) |=> comms_module_ratio_o == RATIO_RST)
    else $error("Comms module ratio set before capture.");

  a_pci_both: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pci1_pll_en_o == pci2_pll_en_o)
    else $error("PCI PLL enables disagree.");

  a_mcheck_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && soft_reset_input_d_r && !ctl_s[4]) |=> machine_check_o ##1 (!machine_check_o || !ce_i))
    else $error("Machine check pulse wrong.");

  a_hard_reset_input_or: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(ctl_s[3] && ctl_s[2]) |=> !core_hard_reset_input_n_o)
    else $error("Hard reset not forwarded.");

  a_trst_or: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(ctl_s[1] && ctl_s[0]) |=> !core_trst_n_o)
    else $error("Test reset not forwarded.");
endmodule
`default_nettype wire

// ### sim/strap_board.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Board side: strap resistors on the ratio pins
// ****************************************
module strap_board (
  input wire logic [3:0] code_i,
  input wire logic [3:0] core_i,
  output logic [3:0] ratio_strap_pins_o,
  output logic [3:0] core_ratio_cfg_o
);
  // Every strap is pulled to a firm level, since the device has no default ratio.
  assign ratio_strap_pins_o = code_i;
  assign core_ratio_cfg_o = core_i;
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clk_ratio_pkg::*;
  logic sys_clk_i, rst_n_i, soft_n, hard_n, dbg_h_n, dbg_t_n, brd_t_n;
  logic [3:0] code, core_cfg, pins, cfg, core_r;
  logic [4:0] ratio, l2, ddr, ccb, comms;
  logic valid, resv, p1, p2, mc, hr_n, tr_n;
  int err_total, compares;

  // ****************************************
  // Device and board straps
  // ****************************************
  strap_board strap_board_i (.code_i(code), .core_i(core_cfg), .ratio_strap_pins_o(pins),
    .core_ratio_cfg_o(cfg));
  // A settle count of one keeps each power-up short.
  platform_clock_ratio_strap #(.SETTLE(1)) platform_clock_ratio_strap_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .ratio_strap_pins_i(pins),
    .core_ratio_cfg_i(cfg), .soft_reset_input_n_i(soft_n), .hard_reset_input_n_i(hard_n),
    .debug_hard_reset_input_n_i(dbg_h_n), .debug_trst_n_i(dbg_t_n), .board_trst_n_i(brd_t_n),
    .platform_ratio_o(ratio), .ratio_valid_o(valid), .ratio_reserved_o(resv),
    .l2_ratio_o(l2), .ddr_ratio_o(ddr), .coherency_bus_ratio_o(ccb), .core_ratio_o(core_r),
    .comms_module_ratio_o(comms), .pci1_pll_en_o(p1), .pci2_pll_en_o(p2),
    .machine_check_o(mc), .core_hard_reset_input_n_o(hr_n), .core_trst_n_o(tr_n));

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Multiplier per strap code; zero stands for a reserved code.
  function automatic logic [4:0] exp_ratio(input logic [3:0] c);
    case (c)
      4'h0: return 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC: return {1'b0, c};
      default: return 5'h00;
    endcase
  endfunction

  // Straps are set during reset so they are stable well before the capture.
  task automatic power_up(input logic [3:0] c, input logic [3:0] cc);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    code <= c;
    core_cfg <= cc;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic test_done;
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic scen_codes;
    logic [4:0] e;
    for (int i = 0; i < 16; i++) begin
      power_up(4'(i), 4'(15 - i));
      e = exp_ratio(4'(i));
      check(8'(ratio), 8'(e));
      check(8'(valid), 8'(e != 5'h00));
      check(8'(resv), 8'(e == 5'h00));
      check(8'(l2), 8'(e));
      check(8'(ddr), 8'(e));
      check(8'(ccb), 8'(e));
      check(8'(core_r), 8'(15 - i));
      check(8'(comms), 8'(COMMS_RATIO));
      check({6'h00, p1, p2}, 8'h03);
    end
  endtask

  // Later pin changes must not move the latched ratio.
  task automatic scen_hold;
    power_up(4'hC, 4'h5);
    @(posedge sys_clk_i);
    code <= 4'h3;
    core_cfg <= 4'hA;
    repeat (10) @(posedge sys_clk_i);
    #1;
    check(8'(ratio), 8'h0C);
    check(8'(core_r), 8'h05);
  endtask

  // The machine check is one pulse per falling edge, not a level.
  task automatic scen_soft;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    soft_n <= 1'b0;
    repeat (16) begin
      @(posedge sys_clk_i);
      #1;
      n += int'(mc === 1'b1);
    end
    check(8'(n), 8'h01);
    @(posedge sys_clk_i);
    soft_n <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // Each reset source alone must pull its core reset low.
  task automatic scen_src(input int k, input logic v);
    @(posedge sys_clk_i);
    case (k)
      0: hard_n <= v;
      1: dbg_h_n <= v;
      2: dbg_t_n <= v;
      default: brd_t_n <= v;
    endcase
    repeat (5) @(posedge sys_clk_i);
    #1;
    check(8'(k < 2 ? hr_n : tr_n), 8'(v));
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #(20000 * 8);
    err_total++;
    test_done();
  end

  initial begin
    {rst_n_i, soft_n, hard_n, dbg_h_n, dbg_t_n, brd_t_n} = 6'h1F;
    code = 4'h0;
    core_cfg = 4'h0;
    err_total = 0;
    compares = 0;
    scen_codes();
    scen_hold();
    scen_soft();
    for (int k = 0; k < 4; k++) begin
      scen_src(k, 1'b0);
      scen_src(k, 1'b1);
    end
    test_done();
  end
endmodule
`default_nettype wire
